// file: src/lmon_pkg.sv
// constants, layouts and carrier types of the line monitor block
// assumes a single 40 MHz clock and 8-bit register frames from the link
package lmon_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1_000;
  localparam int unsigned LATENCY_US    = 250;
  localparam int unsigned SETTLE_128_MS = 128;
  localparam int unsigned SETTLE_64_MS  = 64;
  localparam int unsigned SETTLE_8_MS   = 8;
  localparam int unsigned SETTLE_512_MS = 512;
  localparam int unsigned RCAL_MS       = 17;
  localparam int unsigned ACAL_MS       = 256;
  localparam int unsigned LATENCY_CYC   = LATENCY_US * CYC_PER_US;
  localparam int unsigned SETTLE_128_CYC = SETTLE_128_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_64_CYC = SETTLE_64_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_8_CYC  = SETTLE_8_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_512_CYC = SETTLE_512_MS * CYC_PER_MS;
  localparam int unsigned RCAL_CYC      = RCAL_MS * CYC_PER_MS;
  localparam int unsigned ACAL_CYC      = ACAL_MS * CYC_PER_MS;
  localparam int unsigned TIMER_W       = 25;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [5:0] REG_IRQ_CFG   = 6'h02;
  localparam logic [5:0] REG_IRQ_MASK  = 6'h03;
  localparam logic [5:0] REG_IRQ_FLAG  = 6'h04;
  localparam logic [5:0] REG_HOOK      = 6'h05;
  localparam logic [5:0] REG_LINK_STAT = 6'h0c;
  localparam logic [5:0] REG_CONV_CAL  = 6'h11;
  localparam logic [5:0] REG_LINE_STAT = 6'h13;
  localparam logic [5:0] REG_RES_CAL   = 6'h19;
  localparam logic [5:0] REG_CUR_FINE  = 6'h1c;
  localparam logic [5:0] REG_LINE_VOLT = 6'h1d;
  localparam logic [5:0] REG_HOOK_CFG  = 6'h1f;
  localparam logic [5:0] REG_THR_VAL   = 6'h2b;
  localparam logic [5:0] REG_THR_CFG   = 6'h2c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned BIT_IRQ_OUTPUT_ENABLE  = 7;
  localparam int unsigned BIT_IRQ_OUTPUT_POLARITY  = 6;
  localparam int unsigned BIT_RING  = 7;
  localparam int unsigned SRC_LSB   = 2;
  localparam int unsigned SRC_MSB   = 6;
  localparam int unsigned BIT_POL   = 0;
  localparam int unsigned BIT_HOOK  = 0;
  localparam int unsigned BIT_RDT   = 2;
  localparam int unsigned BIT_FDT   = 6;
  localparam int unsigned BIT_CONVERTER_CAL_DISABLE  = 5;
  localparam int unsigned BIT_DOD   = 1;
  localparam int unsigned BIT_RESISTOR_CAL_DISABLE = 5;
  localparam int unsigned BIT_VOLTAGE_ZERO_FORCE_DISABLE  = 0;
  localparam int unsigned FOH_LSB   = 5;
  localparam int unsigned THR_DIR   = 0;
  localparam int unsigned THR_EN    = 1;
  localparam int unsigned THR_SEL   = 2;
  localparam int unsigned THR_FLAG  = 3;

  // ****************************************
  // values
  // ****************************************
  localparam logic [7:0] IRQ_MASK_USED  = 8'hfd;
  localparam logic [7:0] VOLT_ZERO_LIMIT = 8'h03;
  localparam logic [1:0] FOH_128 = 2'h0;
  localparam logic [1:0] FOH_64  = 2'h1;
  localparam logic [1:0] FOH_8   = 2'h2;
  localparam logic [1:0] FOH_512 = 2'h3;
  localparam logic [7:0] IRQ_CFG_RST = 8'h00;
  localparam logic [7:0] THR_RST     = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SEQ_ONHOOK, SEQ_LATENCY, SEQ_SETTLE, SEQ_RCAL, SEQ_ACAL, SEQ_READY
  } seq_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [4:0] coarse;
    logic [7:0] fine;
    logic [7:0] volt;
  } meas_t;

  typedef struct packed {
    seq_state_t seq;
    logic [7:0] irq_cfg;
    logic [7:0] irq_mask;
    logic [7:0] irq_flag;
    logic       hook;
    logic [1:0] foh;
    logic       voltage_zero_force_disable;
    logic       resistor_cal_disable;
    logic       converter_cal_disable;
    logic [7:0] thr_val;
    logic [3:0] thr_cfg;
    logic [7:0] line_voltage_sense;
    logic [4:0] lcs;
    logic [7:0] lcs2;
    logic [7:0] mag_prev;
    logic       ring_detect_status;
    logic       ring_prev;
    logic [7:0] rdata;
  } lmon_state_t;

  localparam lmon_state_t LMON_RST = '{
    seq: SEQ_ONHOOK, irq_cfg: IRQ_CFG_RST, foh: FOH_128, thr_val: THR_RST,
    default: '0};

endpackage

// file: src/phase_timer.sv
// down counter timing one phase of the off-hook sequence
// assumes load values of at least one
`timescale 1ns/100ps
module phase_timer #(
  parameter int unsigned W = 25
) (
  input  wire logic         clk,      // system clock
  input  wire logic         rst,      // sync reset, high
  input  wire logic         load,     // start a phase
  input  wire logic         abort,    // drop the phase
  input  wire logic [W-1:0] load_val, // phase length in cycles
  output logic              busy,     // phase running
  output logic              done      // last cycle of phase
);

  typedef struct packed {
    logic         armed;
    logic [W-1:0] cnt;
  } tmr_state_t;

  tmr_state_t t_r;
  tmr_state_t t_nxt;

  if (W < 2) begin : g_bad_w
    $error("phase_timer width too small");
  end

  assign busy = t_r.armed;
  assign done = t_r.armed && (t_r.cnt == W'(1));

  always_comb begin
    t_nxt = t_r;
    if (abort) begin
      t_nxt.armed = 1'b0;
    end else if (load) begin
      t_nxt.armed = 1'b1;
      t_nxt.cnt   = load_val;
    end else if (done) begin
      t_nxt.armed = 1'b0;
    end else if (t_r.armed) begin
      t_nxt.cnt = t_r.cnt - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

endmodule // phase_timer

// file: src/line_monitor.sv
// line monitoring, off-hook sequencing and interrupt logic
// assumes register frames arrive as single-cycle read/write strobes
//
// How it works
// - coarse loop current, 5 bits, off-hook only
// - fine loop current, 8 bits, off-hook only
// - line voltage reported on and off hook
// - voltage two's complement, bit 7 polarity
// - polarity toggle sets flag, cleared writing zero
// - polarity event drives pin when enabled
// - small voltages forced zero unless disabled
// - coarse codes pass through unchanged
// - 250 us latency before line side
// - settle counter, selectable duration
// - 17 ms resistor calibration unless disabled
// - 256 ms converter calibration unless disabled
// - pin gated by enable, polarity selectable
// - pin stays active until flags serviced
// - threshold on voltage or fine current
// - threshold fires on rise or fall
// - comparator uses magnitude only
// - measurements only taken with frame detected
// - off-hook event clears ring detect status
`timescale 1ns/100ps
module line_monitor #(
  parameter int unsigned LAT_CYC    = lmon_pkg::LATENCY_CYC,
  parameter int unsigned S128_CYC   = lmon_pkg::SETTLE_128_CYC,
  parameter int unsigned S64_CYC    = lmon_pkg::SETTLE_64_CYC,
  parameter int unsigned S8_CYC     = lmon_pkg::SETTLE_8_CYC,
  parameter int unsigned S512_CYC   = lmon_pkg::SETTLE_512_CYC,
  parameter int unsigned R_CAL_CYC  = lmon_pkg::RCAL_CYC,
  parameter int unsigned A_CAL_CYC  = lmon_pkg::ACAL_CYC
) (
  input  wire logic             clk,            // 40 MHz clock
  input  wire logic             rst,            // sync reset, high
  input  wire lmon_pkg::reg_req_t req,          // register frame strobe
  output logic [7:0]            reg_rdata,      // read data, next cycle
  input  wire lmon_pkg::meas_t  meas,           // line side samples
  input  wire logic             frame_ok,       // line side link up
  input  wire logic             ring_detect_in, // ring one-shot level
  input  wire logic             dropout_in,     // line supply collapsed
  input  wire logic [4:0]       src_events,     // other irq sources
  output logic                  offhook_cmd,    // hook request to line
  output logic                  line_offhook,   // line side off-hook
  output logic                  path_enable,    // tx/rx allowed
  output logic                  rcal_active,    // resistor cal running
  output logic                  acal_active,    // converter cal running
  output logic                  irq_output_pin  // interrupt pin
);

  localparam int unsigned TW = lmon_pkg::TIMER_W;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (LAT_CYC == 0 || S128_CYC == 0 || S64_CYC == 0 || S8_CYC == 0 ||
      S512_CYC == 0 || R_CAL_CYC == 0 || A_CAL_CYC == 0) begin : g_bad0
    $error("phase lengths must be at least one cycle");
  end
  if (LAT_CYC >= 2**TW || S512_CYC >= 2**TW || A_CAL_CYC >= 2**TW ||
      S128_CYC >= 2**TW || R_CAL_CYC >= 2**TW) begin : g_badw
    $error("phase length exceeds timer width");
  end

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [7:0] mag8(input logic [7:0] v);
    return v[7] ? 8'(~v + 8'h01) : v;
  endfunction

  function automatic logic [TW-1:0] settle_len(input logic [1:0] sel);
    logic [TW-1:0] r;
    unique case (sel)
      lmon_pkg::FOH_128: r = TW'(S128_CYC);
      lmon_pkg::FOH_64:  r = TW'(S64_CYC);
      lmon_pkg::FOH_8:   r = TW'(S8_CYC);
      lmon_pkg::FOH_512: r = TW'(S512_CYC);
    endcase
    return r;
  endfunction

  // ****************************************
  // state
  // ****************************************
  lmon_pkg::lmon_state_t s_r;
  lmon_pkg::lmon_state_t s_nxt;
  logic                  t_load;
  logic                  t_abort;
  logic [TW-1:0]         t_val;
  logic                  t_done;
  logic                  t_busy;
  logic                  offhook_evt;
  logic                  pol_evt;
  logic                  thr_evt;
  logic                  ring_rise;
  logic                  irq_active;
  logic [7:0]            lvs_new;
  logic [7:0]            cur_mag;
  logic [7:0]            set_vec;
  logic [7:0]            flag_base;
  logic                  thr_flag_base;

  phase_timer #(.W(TW)) u_timer (
    .clk      (clk),
    .rst      (rst),
    .load     (t_load),
    .abort    (t_abort),
    .load_val (t_val),
    .busy     (t_busy),
    .done     (t_done)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata    = s_r.rdata;
  assign offhook_cmd  = s_r.hook;
  assign line_offhook = (s_r.seq != lmon_pkg::SEQ_ONHOOK) &&
                        (s_r.seq != lmon_pkg::SEQ_LATENCY);
  assign path_enable  = s_r.seq == lmon_pkg::SEQ_READY;
  assign rcal_active  = s_r.seq == lmon_pkg::SEQ_RCAL;
  assign acal_active  = s_r.seq == lmon_pkg::SEQ_ACAL;

  assign irq_active = s_r.irq_cfg[lmon_pkg::BIT_IRQ_OUTPUT_ENABLE] &&
      ((|(s_r.irq_flag & s_r.irq_mask)) ||
       (s_r.thr_cfg[lmon_pkg::THR_EN] && s_r.thr_cfg[lmon_pkg::THR_FLAG]));
  assign irq_output_pin = s_r.irq_cfg[lmon_pkg::BIT_IRQ_OUTPUT_POLARITY] ?
                          irq_active : ~irq_active;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt       = s_r;
    t_load      = 1'b0;
    t_abort     = 1'b0;
    t_val       = TW'(LAT_CYC);
    offhook_evt = 1'b0;
    pol_evt     = 1'b0;
    thr_evt     = 1'b0;

    // off-hook sequence
    unique case (s_r.seq)
      lmon_pkg::SEQ_ONHOOK: begin
        if (s_r.hook) begin
          t_load    = 1'b1;
          s_nxt.seq = lmon_pkg::SEQ_LATENCY;
        end
      end
      lmon_pkg::SEQ_LATENCY: begin
        if (t_done) begin
          t_load      = 1'b1;
          t_val       = settle_len(s_r.foh);
          offhook_evt = 1'b1;
          s_nxt.seq   = lmon_pkg::SEQ_SETTLE;
        end
      end
      lmon_pkg::SEQ_SETTLE: begin
        if (t_done) begin
          if (!s_r.resistor_cal_disable) begin
            t_load    = 1'b1;
            t_val     = TW'(R_CAL_CYC);
            s_nxt.seq = lmon_pkg::SEQ_RCAL;
          end else if (!s_r.converter_cal_disable) begin
            t_load    = 1'b1;
            t_val     = TW'(A_CAL_CYC);
            s_nxt.seq = lmon_pkg::SEQ_ACAL;
          end else begin
            s_nxt.seq = lmon_pkg::SEQ_READY;
          end
        end
      end
      lmon_pkg::SEQ_RCAL: begin
        if (t_done) begin
          if (!s_r.converter_cal_disable) begin
            t_load    = 1'b1;
            t_val     = TW'(A_CAL_CYC);
            s_nxt.seq = lmon_pkg::SEQ_ACAL;
          end else begin
            s_nxt.seq = lmon_pkg::SEQ_READY;
          end
        end
      end
      lmon_pkg::SEQ_ACAL: begin
        if (t_done) begin
          s_nxt.seq = lmon_pkg::SEQ_READY;
        end
      end
      lmon_pkg::SEQ_READY: begin
      end
      default: begin
        s_nxt.seq = lmon_pkg::SEQ_ONHOOK;
      end
    endcase
    if (!s_r.hook && s_r.seq != lmon_pkg::SEQ_ONHOOK) begin
      t_load    = 1'b0;
      t_abort   = 1'b1;
      s_nxt.seq = lmon_pkg::SEQ_ONHOOK;
    end

    // measurements, taken only while the link is up
    lvs_new = (!s_r.voltage_zero_force_disable && mag8(meas.volt) <= lmon_pkg::VOLT_ZERO_LIMIT) ?
              8'h00 : meas.volt;
    cur_mag = s_r.thr_cfg[lmon_pkg::THR_SEL] ? s_r.lcs2 : mag8(s_r.line_voltage_sense);
    if (frame_ok) begin
      s_nxt.line_voltage_sense  = lvs_new;
      s_nxt.lcs  = line_offhook ? meas.coarse : 5'h00;
      s_nxt.lcs2 = line_offhook ? meas.fine : 8'h00;
      pol_evt    = lvs_new[7] ^ s_r.line_voltage_sense[7];
      s_nxt.mag_prev = cur_mag;
      if (s_r.thr_cfg[lmon_pkg::THR_DIR]) begin
        thr_evt = (s_r.mag_prev >= s_r.thr_val) && (cur_mag < s_r.thr_val);
      end else begin
        thr_evt = (s_r.mag_prev <= s_r.thr_val) && (cur_mag > s_r.thr_val);
      end
    end

    // ring detect status
    ring_rise       = ring_detect_in && !s_r.ring_prev;
    s_nxt.ring_prev = ring_detect_in;
    s_nxt.ring_detect_status = offhook_evt ? 1'b0 :
                (ring_detect_in && (s_r.ring_detect_status || ring_rise));

    // sticky flags, a set in the clearing cycle wins
    set_vec = 8'h00;
    set_vec[lmon_pkg::BIT_RING] = ring_rise;
    set_vec[lmon_pkg::SRC_MSB:lmon_pkg::SRC_LSB] = src_events;
    set_vec[lmon_pkg::BIT_POL] = pol_evt;
    flag_base     = s_r.irq_flag;
    thr_flag_base = s_r.thr_cfg[lmon_pkg::THR_FLAG];

    // register writes
    if (req.wr) begin
      unique case (req.addr)
        lmon_pkg::REG_IRQ_CFG:  s_nxt.irq_cfg = req.wdata;
        lmon_pkg::REG_IRQ_MASK: s_nxt.irq_mask =
                                req.wdata & lmon_pkg::IRQ_MASK_USED;
        lmon_pkg::REG_IRQ_FLAG: flag_base = s_r.irq_flag & req.wdata;
        lmon_pkg::REG_HOOK:     s_nxt.hook = req.wdata[lmon_pkg::BIT_HOOK];
        lmon_pkg::REG_CONV_CAL: s_nxt.converter_cal_disable = req.wdata[lmon_pkg::BIT_CONVERTER_CAL_DISABLE];
        lmon_pkg::REG_RES_CAL:  s_nxt.resistor_cal_disable = req.wdata[lmon_pkg::BIT_RESISTOR_CAL_DISABLE];
        lmon_pkg::REG_HOOK_CFG: begin
          s_nxt.foh  = req.wdata[lmon_pkg::FOH_LSB +: 2];
          s_nxt.voltage_zero_force_disable = req.wdata[lmon_pkg::BIT_VOLTAGE_ZERO_FORCE_DISABLE];
        end
        lmon_pkg::REG_THR_VAL:  s_nxt.thr_val = req.wdata;
        lmon_pkg::REG_THR_CFG: begin
          s_nxt.thr_cfg[2:0] = req.wdata[2:0];
          thr_flag_base = thr_flag_base & req.wdata[lmon_pkg::THR_FLAG];
        end
        default: begin end
      endcase
    end
    s_nxt.irq_flag = (flag_base | set_vec) & lmon_pkg::IRQ_MASK_USED;
    s_nxt.thr_cfg[lmon_pkg::THR_FLAG] = thr_flag_base | thr_evt;

    // register reads
    if (req.rd) begin
      s_nxt.rdata = 8'h00;
      unique case (req.addr)
        lmon_pkg::REG_IRQ_CFG:   s_nxt.rdata = s_r.irq_cfg;
        lmon_pkg::REG_IRQ_MASK:  s_nxt.rdata = s_r.irq_mask;
        lmon_pkg::REG_IRQ_FLAG:  s_nxt.rdata = s_r.irq_flag;
        lmon_pkg::REG_HOOK: begin
          s_nxt.rdata[lmon_pkg::BIT_HOOK] = s_r.hook;
          s_nxt.rdata[lmon_pkg::BIT_RDT]  = s_r.ring_detect_status;
        end
        lmon_pkg::REG_LINK_STAT: begin
          s_nxt.rdata[lmon_pkg::BIT_FDT] = frame_ok;
          s_nxt.rdata[4:0] = s_r.lcs;
        end
        lmon_pkg::REG_CONV_CAL:  s_nxt.rdata[lmon_pkg::BIT_CONVERTER_CAL_DISABLE] = s_r.converter_cal_disable;
        lmon_pkg::REG_LINE_STAT: s_nxt.rdata[lmon_pkg::BIT_DOD] = dropout_in;
        lmon_pkg::REG_RES_CAL:   s_nxt.rdata[lmon_pkg::BIT_RESISTOR_CAL_DISABLE] = s_r.resistor_cal_disable;
        lmon_pkg::REG_CUR_FINE:  s_nxt.rdata = s_r.lcs2;
        lmon_pkg::REG_LINE_VOLT: s_nxt.rdata = s_r.line_voltage_sense;
        lmon_pkg::REG_HOOK_CFG: begin
          s_nxt.rdata[lmon_pkg::FOH_LSB +: 2] = s_r.foh;
          s_nxt.rdata[lmon_pkg::BIT_VOLTAGE_ZERO_FORCE_DISABLE] = s_r.voltage_zero_force_disable;
        end
        lmon_pkg::REG_THR_VAL:   s_nxt.rdata = s_r.thr_val;
        lmon_pkg::REG_THR_CFG:   s_nxt.rdata[3:0] = s_r.thr_cfg;
        default: begin end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= lmon_pkg::LMON_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  int unsigned dwell_r;

  always_ff @(posedge clk) begin
    if (rst || s_nxt.seq != s_r.seq) begin
      dwell_r <= 0;
    end else begin
      dwell_r <= dwell_r + 1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_COARSE_ONHOOK: assert property (
    frame_ok && s_r.seq == lmon_pkg::SEQ_ONHOOK |=> s_r.lcs == 5'h00)
    else $error("coarse current nonzero while on-hook");
  AST_FINE_TRACK: assert property (
    frame_ok && line_offhook |=> s_r.lcs2 == $past(meas.fine))
    else $error("fine current not reported off-hook");
  AST_VOLT_TRACK: assert property (
    frame_ok && s_r.voltage_zero_force_disable ##0 !req.wr |=> s_r.line_voltage_sense == $past(meas.volt))
    else $error("line voltage not reported");
  AST_VOLT_ZERO: assert property (
    frame_ok && !s_r.voltage_zero_force_disable && mag8(meas.volt) <= 8'h03 |=> s_r.line_voltage_sense == 8'h00)
    else $error("small voltage not forced to zero");
  AST_POL_FLAG: assert property (
    frame_ok && (lvs_new[7] != s_r.line_voltage_sense[7]) |=> s_r.irq_flag[0])
    else $error("polarity change flag not set");
  AST_PIN_OFF: assert property (
    !s_r.irq_cfg[7] |-> irq_output_pin == !s_r.irq_cfg[6])
    else $error("interrupt pin active while disabled");
  AST_PIN_HOLD: assert property (
    s_r.irq_cfg[7] && (|(s_r.irq_flag & s_r.irq_mask)) |->
      irq_output_pin == s_r.irq_cfg[6])
    else $error("interrupt pin not active with pending flag");
  AST_LATENCY: assert property (
    s_r.seq == lmon_pkg::SEQ_LATENCY && s_nxt.seq == lmon_pkg::SEQ_SETTLE
      |-> dwell_r == LAT_CYC - 1)
    else $error("off-hook latency length wrong");
  AST_RCAL_LEN: assert property (
    s_r.seq == lmon_pkg::SEQ_RCAL && s_nxt.seq != lmon_pkg::SEQ_RCAL &&
      s_r.hook |-> dwell_r == R_CAL_CYC - 1)
    else $error("resistor calibration length wrong");
  AST_ACAL_LEN: assert property (
    s_r.seq == lmon_pkg::SEQ_ACAL && s_nxt.seq != lmon_pkg::SEQ_ACAL &&
      s_r.hook |-> dwell_r == A_CAL_CYC - 1)
    else $error("converter calibration length wrong");
  AST_ABORT: assert property (
    !s_r.hook && s_r.seq != lmon_pkg::SEQ_ONHOOK |=>
      s_r.seq == lmon_pkg::SEQ_ONHOOK && !t_busy)
    else $error("sequence not aborted on hook release");
  AST_RDT_CLEAR: assert property (
    s_r.seq == lmon_pkg::SEQ_LATENCY ##1 s_r.seq == lmon_pkg::SEQ_SETTLE
      |-> !s_r.ring_detect_status)
    else $error("ring status survived off-hook");
  AST_THR_FLAG: assert property (
    thr_evt |=> s_r.thr_cfg[3])
    else $error("threshold crossing not flagged");

  COV_READY: cover property (s_r.seq == lmon_pkg::SEQ_ACAL ##1
                             s_r.seq == lmon_pkg::SEQ_READY);
  COV_SKIP_CAL: cover property (s_r.seq == lmon_pkg::SEQ_SETTLE ##1
                                s_r.seq == lmon_pkg::SEQ_READY);
  COV_POL_IRQ: cover property (pol_evt && s_r.irq_cfg[7] && s_r.irq_mask[0]);
  COV_THR_FALL: cover property (thr_evt && s_r.thr_cfg[0]);

endmodule // line_monitor

// file: verif/line_side_model.sv
// line-side stand-in: measurement samples and link status
// assumes the bench calls set_line from its own process
`timescale 1ns/100ps
module line_side_model (
  input  wire logic clk,        // system clock
  output lmon_pkg::meas_t meas, // line samples
  output logic      frame_ok,   // link up
  output logic      ring,       // ring level
  output logic      drop        // supply collapse
);
  initial begin
    meas = '0;
    frame_ok = 1'b1;
    ring = 1'b0;
    drop = 1'b0;
  end
  task automatic set_line(input logic [7:0] v, input logic [7:0] f,
                          input logic [4:0] c);
    @(negedge clk);
    meas = '{coarse: c, fine: f, volt: v};
  endtask
  task automatic set_aux(input logic f, input logic r, input logic d);
    @(negedge clk);
    frame_ok = f;
    ring = r;
    drop = d;
  endtask
endmodule // line_side_model

// file: verif/tb_top.sv
// self-checking bench for the line monitor
// assumes shortened phase lengths set below
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lmon_pkg::reg_req_t req = '0;
  lmon_pkg::meas_t meas;
  logic [4:0] src = '0;
  logic [7:0] rdat, v;
  logic frame_ok, ring, drop, ohc, loh, pen, rca, aca, pin;
  logic rd_d = 1'b0;
  logic [15:0] rq[$];
  logic [15:0] note;
  int bad_count = 0;
  int checks_done = 0;
  int seed = 64;
  int n, nr, na;
  int settle[4] = '{20, 16, 12, 24};
  logic [4:0] cc[4] = '{5'h00, 5'h04, 5'h1f, 5'h0a};
  always #12.5 clk = ~clk;
  line_side_model i_line (.clk(clk), .meas(meas), .frame_ok(frame_ok),
    .ring(ring), .drop(drop));
  line_monitor #(.LAT_CYC(8), .S128_CYC(20), .S64_CYC(16), .S8_CYC(12),
    .S512_CYC(24), .R_CAL_CYC(6), .A_CAL_CYC(10)) i_dut (.clk(clk),
    .rst(rst), .req(req), .reg_rdata(rdat), .meas(meas),
    .frame_ok(frame_ok), .ring_detect_in(ring), .dropout_in(drop),
    .src_events(src), .offhook_cmd(ohc), .line_offhook(loh),
    .path_enable(pen), .rcal_active(rca), .acal_active(aca),
    .irq_output_pin(pin));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    rq.push_back({m, e});
    @(negedge clk);
    req.rd = 1'b0;
  endtask
  task automatic thr(input logic [7:0] cfg, input logic [7:0] a,
                     input logic [7:0] b, input logic [7:0] e);
    i_line.set_line(cfg[2] ? 8'h00 : a, cfg[2] ? a : 8'h00, 5'h00);
    wr(6'h2c, cfg);
    i_line.set_line(cfg[2] ? 8'h00 : b, cfg[2] ? b : 8'h00, 5'h00);
    @(negedge clk);
    rd(6'h2c, 8'h08, e);
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // read results leave the queue as they appear
  always @(posedge clk) rd_d <= req.rd;
  always @(negedge clk) if (rd_d === 1'b1) begin
    note = rq.pop_front();
    chk(rdat & note[15:8], note[7:0]);
  end
  initial begin
    #(25 * 4000);
    bad_count++;
    finish_test();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({7'h0, pin}, 8'h01);
    rd(6'h1d, 8'hff, 8'h00);
    rd(6'h3f, 8'hff, 8'h00);
    wr(6'h02, 8'h80);
    wr(6'h03, 8'h05);
    i_line.set_line(8'hf6, 8'h00, 5'h00);
    repeat (2) @(negedge clk);
    chk({7'h0, pin}, 8'h00);
    rd(6'h1d, 8'hff, 8'hf6);
    rd(6'h04, 8'h01, 8'h01);
    wr(6'h04, 8'h00);
    chk({7'h0, pin}, 8'h01);
    @(negedge clk) src = 5'h01;
    @(negedge clk) src = 5'h00;
    rd(6'h04, 8'h04, 8'h04);
    chk({7'h0, pin}, 8'h00);
    wr(6'h04, 8'h00);
    wr(6'h02, 8'hc0);
    chk({7'h0, pin}, 8'h00);
    i_line.set_line(8'h02, 8'h00, 5'h00);
    repeat (2) @(negedge clk);
    chk({7'h0, pin}, 8'h01);
    rd(6'h1d, 8'hff, 8'h00);
    wr(6'h1f, 8'h01);
    rd(6'h1d, 8'hff, 8'h02);
    repeat (4) begin
      v = 8'($random(seed));
      i_line.set_line(v, v ^ 8'h5a, 5'h00);
      rd(6'h1d, 8'hff, v);
      rd(6'h1c, 8'hff, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      i_line.set_line(8'h30, 8'h20, cc[i]);
      wr(6'h1f, 8'(i << 5));
      wr(6'h19, {2'h0, i[0], 5'h0});
      wr(6'h11, {2'h0, i[1], 5'h0});
      wr(6'h05, 8'h01);
      n = 0;
      nr = 0;
      na = 0;
      while (pen !== 1'b1 && n < 200) begin
        @(negedge clk);
        n++;
        nr += int'(rca === 1'b1);
        na += int'(aca === 1'b1);
      end
      chk(8'(n), 8'(9 + settle[i] + (i[0] ? 0 : 6) + (i[1] ? 0 : 10)));
      chk(8'(nr), 8'(i[0] ? 0 : 6));
      chk(8'(na), 8'(i[1] ? 0 : 10));
      rd(6'h0c, 8'h1f, {3'h0, cc[i]});
      rd(6'h1c, 8'hff, 8'h20);
      wr(6'h05, 8'h00);
      @(negedge clk);
      chk({7'h0, pen}, 8'h00);
      repeat (2) @(negedge clk);
      rd(6'h0c, 8'h1f, 8'h00);
    end
    wr(6'h05, 8'h01);
    repeat (8) @(negedge clk);
    chk({6'h0, ohc, loh}, 8'h02);
    @(negedge clk);
    chk({7'h0, loh}, 8'h01);
    wr(6'h05, 8'h00);
    repeat (40) @(negedge clk);
    chk({6'h0, loh, pen}, 8'h00);
    i_line.set_aux(1'b1, 1'b1, 1'b1);
    @(negedge clk);
    rd(6'h05, 8'h04, 8'h04);
    rd(6'h04, 8'h80, 8'h80);
    rd(6'h13, 8'h02, 8'h02);
    wr(6'h05, 8'h01);
    repeat (12) @(negedge clk);
    rd(6'h05, 8'h05, 8'h01);
    wr(6'h2b, 8'h40);
    thr(8'h06, 8'h30, 8'h50, 8'h08);
    thr(8'h07, 8'h50, 8'h30, 8'h08);
    thr(8'h02, 8'h10, 8'hb0, 8'h08);
    thr(8'h02, 8'h10, 8'he0, 8'h00);
    i_line.set_aux(1'b0, 1'b0, 1'b0);
    i_line.set_line(8'h7f, 8'h00, 5'h00);
    @(negedge clk);
    rd(6'h1d, 8'hff, 8'he0);
    rd(6'h0c, 8'h40, 8'h00);
    repeat (2) @(negedge clk);
    finish_test();
  end
endmodule // tb_top
